// file: door_diag_pkg.sv
package door_diag_pkg;

  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned T_TICK_MS = 1;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * T_TICK_MS;
  localparam logic [9:0]  MS_PER_S  = 10'h3E8;

  localparam logic [3:0] R_SUBST    = 4'h0;
  localparam logic [3:0] R_FREQ_DETECTOR_0     = 4'h1;
  localparam logic [3:0] R_FREQ_DETECTOR_1     = 4'h2;
  localparam logic [3:0] R_AND0_ON  = 4'h3;
  localparam logic [3:0] R_AND0_OFF = 4'h4;
  localparam logic [3:0] R_AND1_ON  = 4'h5;
  localparam logic [3:0] R_AND1_OFF = 4'h6;
  localparam logic [3:0] R_ERM      = 4'h7;
  localparam logic [3:0] R_STATUS   = 4'h8;

  localparam logic [15:0] RST_SUBST = 16'h0302;
  localparam logic        RST_FSEL  = 1'h0;
  localparam logic [15:0] RST_DISC  = 16'h00FA;
  localparam logic [15:0] RST_ERM   = 16'h000A;
  localparam logic [15:0] DISC_MAX  = 16'h03E8;

  localparam int unsigned SUBST_LSB   = 0;
  localparam int unsigned SFERR_LSB   = 8;
  localparam int unsigned SW1_ERR_BIT = 3;
  localparam int unsigned CW1_ACK_BIT = 7;

  localparam logic [15:0] ESTOP_WAIT_S = 16'h0005;
  localparam logic [11:0] FRQ_P0_MS    = 12'h7D0;
  localparam logic [11:0] FRQ_P1_MS    = 12'h3E8;
  localparam logic [11:0] FRQ_TOL_MS   = 12'h064;

  localparam int unsigned NEV = 8;

  typedef enum logic [1:0] {
    CLS_NONE  = 2'h0,
    CLS_INFO  = 2'h1,
    CLS_WARN  = 2'h2,
    CLS_FAULT = 2'h3
  } ev_class_t;

  typedef struct packed {
    ev_class_t  cls;
    logic [7:0] code;
  } ev_t;

  typedef struct packed {
    logic        estop;
    logic        log_en;
    logic [3:0]  prio;
    logic [15:0] wait_s;
    ev_t         ev;
  } ev_desc_t;

  // Event catalogue stub; lower prio value ranks first within a class
  localparam ev_desc_t EV_TAB [NEV] = '{
    '{1'h1, 1'h1, 4'h9, 16'h0005, '{CLS_FAULT, 8'h01}},
    '{1'h0, 1'h1, 4'hC, 16'h003C, '{CLS_FAULT, 8'h03}},
    '{1'h1, 1'h1, 4'h7, 16'h0005, '{CLS_FAULT, 8'h07}},
    '{1'h1, 1'h1, 4'h8, 16'h000A, '{CLS_FAULT, 8'h05}},
    '{1'h0, 1'h1, 4'h2, 16'h0000, '{CLS_WARN,  8'h20}},
    '{1'h0, 1'h0, 4'h5, 16'h0000, '{CLS_WARN,  8'h21}},
    '{1'h0, 1'h0, 4'h1, 16'h0000, '{CLS_INFO,  8'h40}},
    '{1'h0, 1'h0, 4'h2, 16'h0000, '{CLS_INFO,  8'h41}}
  };

endpackage

// file: door_diag.sv
`timescale 1ns/1ps
module door_diag #(
  parameter int unsigned MS_CYCLES = door_diag_pkg::MS_CYCLES
) (
  input  wire logic                          sys_clk_i,
  input  wire logic                          nrst_i,
  input  wire logic                          ce_i,
  input  wire logic [3:0]                    addr_i,
  input  wire logic [15:0]                   wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [15:0]                   rdata_o,
  input  wire logic [door_diag_pkg::NEV-1:0] ev_active_i,
  input  wire logic                          online_i,
  input  wire logic [15:0]                   control_word_i,
  output logic      [15:0]                   status_word_o,
  input  wire logic                          term_ack_i,
  output logic      [7:0]                    seg_code_o,
  output logic      [7:0]                    event_code_o,
  output logic                               motor_en_o,
  output logic                               door_stop_o,
  output logic                               selftest_req_o,
  input  wire logic                          selftest_done_i,
  output door_diag_pkg::ev_t                 log_entry_o,
  output logic                               log_wr_o,
  input  wire logic [1:0]                    and_a_i,
  input  wire logic [1:0]                    and_b_i,
  input  wire logic [1:0]                    frq_in_i,
  input  wire logic                          erm_in_i,
  output logic      [1:0]                    and_o,
  output logic      [1:0]                    frq_det_o,
  output logic      [3:0]                    subst_show_o,
  output logic      [3:0]                    sf_err_o,
  output logic                               erm_o
);

  localparam int unsigned NEV = door_diag_pkg::NEV;

  typedef enum logic [1:0] {ST_RUN, ST_FAULT, ST_WAIT, ST_TEST} rec_state_t;

  rec_state_t      st_q;
  logic [7:0]      s1_q, s2_q, s3_q;
  logic [31:0]     ms_cnt_q;
  logic [9:0]      sec_cnt_q;
  logic            ms_tick, sec_tick;
  logic [15:0]     cfg_q, erm_dly_q;
  logic [1:0]      fsel_q;
  logic [15:0]     on_dly_q [2];
  logic [15:0]     off_dly_q [2];
  logic [1:0]      disc_q, frq_err_q;
  logic [3:0]      blk_fault;
  logic [15:0]     erm_cnt_q, wait_q, max_wait;
  logic [NEV-1:0]  fault_q, fault_set, pend_q, ev_prev_q, log_rise, grant;
  logic            cw_ack_q, fb_rise, term_rise, ack_take, estop_any;
  door_diag_pkg::ev_t top;
  logic [3:0]      top_prio;
  logic [2:0]      log_idx;

  function automatic logic [15:0] clamp_disc(input logic [15:0] v);
    clamp_disc = (v > door_diag_pkg::DISC_MAX) ? door_diag_pkg::DISC_MAX : v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: {term, erm, frq[1:0], b[1:0], a[1:0]}
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
    end else if (ce_i) begin
      s1_q <= {term_ack_i, erm_in_i, frq_in_i, and_b_i, and_a_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Millisecond and second ticks, realigned on acknowledge
  assign ms_tick  = (ms_cnt_q == MS_CYCLES - 1);
  assign sec_tick = ms_tick && (sec_cnt_q == door_diag_pkg::MS_PER_S - 10'h001);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ms_cnt_q  <= 32'h0000_0000;
      sec_cnt_q <= 10'h000;
    end else if (ce_i) begin
      if (ack_take || ms_tick) ms_cnt_q <= 32'h0000_0000;
      else ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
      if (ack_take || sec_tick) sec_cnt_q <= 10'h000;
      else if (ms_tick) sec_cnt_q <= sec_cnt_q + 10'h001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_q     <= door_diag_pkg::RST_SUBST;
      fsel_q    <= {2{door_diag_pkg::RST_FSEL}};
      on_dly_q  <= '{door_diag_pkg::RST_DISC, door_diag_pkg::RST_DISC};
      off_dly_q <= '{door_diag_pkg::RST_DISC, door_diag_pkg::RST_DISC};
      erm_dly_q <= door_diag_pkg::RST_ERM;
    end else if (ce_i && wr_i) begin
      unique case (addr_i)
        door_diag_pkg::R_SUBST:    cfg_q        <= wdata_i;
        door_diag_pkg::R_FREQ_DETECTOR_0:     fsel_q[0]    <= wdata_i[0];
        door_diag_pkg::R_FREQ_DETECTOR_1:     fsel_q[1]    <= wdata_i[0];
        door_diag_pkg::R_AND0_ON:  on_dly_q[0]  <= clamp_disc(wdata_i);
        door_diag_pkg::R_AND0_OFF: off_dly_q[0] <= clamp_disc(wdata_i);
        door_diag_pkg::R_AND1_ON:  on_dly_q[1]  <= clamp_disc(wdata_i);
        door_diag_pkg::R_AND1_OFF: off_dly_q[1] <= clamp_disc(wdata_i);
        door_diag_pkg::R_ERM:      erm_dly_q    <= wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      rdata_o <= 16'h0000;
      if (rd_i) begin
        unique case (addr_i)
          door_diag_pkg::R_SUBST:    rdata_o <= cfg_q;
          door_diag_pkg::R_FREQ_DETECTOR_0:     rdata_o <= {15'h0000, fsel_q[0]};
          door_diag_pkg::R_FREQ_DETECTOR_1:     rdata_o <= {15'h0000, fsel_q[1]};
          door_diag_pkg::R_AND0_ON:  rdata_o <= on_dly_q[0];
          door_diag_pkg::R_AND0_OFF: rdata_o <= off_dly_q[0];
          door_diag_pkg::R_AND1_ON:  rdata_o <= on_dly_q[1];
          door_diag_pkg::R_AND1_OFF: rdata_o <= off_dly_q[1];
          door_diag_pkg::R_ERM:      rdata_o <= erm_dly_q;
          door_diag_pkg::R_STATUS:   rdata_o <= {5'h00, |fault_q, st_q, top.code};
          default:                   rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Dual-channel AND blocks and frequency detectors
  for (genvar g = 0; g < 2; g++) begin : g_blk
    logic        agree_q, seen_q;
    logic [15:0] dt_q;
    logic [11:0] per_q, tgt;
    logic        a, b, fin, frise, in_win;

    assign a      = s2_q[g];
    assign b      = s2_q[2+g];
    assign fin    = s2_q[4+g];
    assign frise  = fin && !s3_q[4+g];
    assign tgt    = fsel_q[g] ? door_diag_pkg::FRQ_P1_MS : door_diag_pkg::FRQ_P0_MS;
    assign in_win = (per_q + door_diag_pkg::FRQ_TOL_MS >= tgt)
                 && (per_q <= tgt + door_diag_pkg::FRQ_TOL_MS);

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        agree_q   <= 1'h0;
        dt_q      <= 16'h0000;
        disc_q[g] <= 1'h0;
        and_o[g]  <= 1'h0;
      end else if (ce_i) begin
        if (a != b) begin
          // Off delay if both were high before, on delay otherwise
          if (dt_q >= (agree_q ? off_dly_q[g] : on_dly_q[g])) disc_q[g] <= 1'h1;
          else if (ms_tick) dt_q <= dt_q + 16'h0001;
        end else begin
          dt_q    <= 16'h0000;
          agree_q <= a;
          if (!a) disc_q[g] <= 1'h0;
        end
        and_o[g] <= a && b && !disc_q[g];
      end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        per_q        <= 12'h000;
        seen_q       <= 1'h0;
        frq_det_o[g] <= 1'h0;
        frq_err_q[g] <= 1'h0;
      end else if (ce_i) begin
        if (frise) begin
          per_q        <= 12'h000;
          seen_q       <= 1'h1;
          frq_det_o[g] <= seen_q && in_win;
          frq_err_q[g] <= seen_q && !in_win;
        end else begin
          if (ms_tick && per_q != 12'hFFF) per_q <= per_q + 12'h001;
          if (per_q > tgt + door_diag_pkg::FRQ_TOL_MS) begin
            frq_det_o[g] <= 1'h0;
            frq_err_q[g] <= seen_q;
          end
        end
      end
    end
  end

  assign blk_fault = {frq_err_q, disc_q};

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      subst_show_o <= 4'h0;
      sf_err_o     <= 4'h0;
    end else if (ce_i) begin
      subst_show_o <= cfg_q[door_diag_pkg::SUBST_LSB +: 4] & blk_fault;
      sf_err_o     <= cfg_q[door_diag_pkg::SFERR_LSB +: 4] & blk_fault;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Emergency release with off delay in seconds
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      erm_o     <= 1'h0;
      erm_cnt_q <= 16'h0000;
    end else if (ce_i) begin
      if (s2_q[6]) begin
        erm_o     <= 1'h1;
        erm_cnt_q <= erm_dly_q;
      end else if (erm_o) begin
        if (erm_cnt_q == 16'h0000) erm_o <= 1'h0;
        else if (sec_tick) erm_cnt_q <= erm_cnt_q - 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event ranking, wait time and log selection
  always_comb begin
    top       = '{door_diag_pkg::CLS_NONE, 8'h00};
    top_prio  = 4'hF;
    fault_set = '0;
    max_wait  = 16'h0000;
    estop_any = 1'h0;
    log_rise  = '0;
    log_idx   = 3'h0;
    grant     = '0;
    for (int i = NEV - 1; i >= 0; i--) begin
      fault_set[i] = ev_active_i[i] && (door_diag_pkg::EV_TAB[i].ev.cls == door_diag_pkg::CLS_FAULT);
      log_rise[i]  = ev_active_i[i] && !ev_prev_q[i] && door_diag_pkg::EV_TAB[i].log_en
                  && (door_diag_pkg::EV_TAB[i].ev.cls >= door_diag_pkg::CLS_WARN);
      if (pend_q[i]) log_idx = i[2:0];
      if (fault_q[i] || (ev_active_i[i] && !fault_set[i])) begin
        if (door_diag_pkg::EV_TAB[i].ev.cls > top.cls
            || (door_diag_pkg::EV_TAB[i].ev.cls == top.cls
                && door_diag_pkg::EV_TAB[i].prio <= top_prio)) begin
          top      = door_diag_pkg::EV_TAB[i].ev;
          top_prio = door_diag_pkg::EV_TAB[i].prio;
        end
      end
      if (fault_q[i]) begin
        if (door_diag_pkg::EV_TAB[i].wait_s > max_wait) max_wait = door_diag_pkg::EV_TAB[i].wait_s;
        estop_any = estop_any || door_diag_pkg::EV_TAB[i].estop;
      end
    end
    if (estop_any && max_wait < door_diag_pkg::ESTOP_WAIT_S) max_wait = door_diag_pkg::ESTOP_WAIT_S;
    if (|pend_q) grant[log_idx] = 1'h1;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_prev_q   <= '0;
      pend_q      <= '0;
      log_wr_o    <= 1'h0;
      log_entry_o <= '{door_diag_pkg::CLS_NONE, 8'h00};
    end else if (ce_i) begin
      ev_prev_q <= ev_active_i;
      pend_q    <= (pend_q & ~grant) | log_rise;
      log_wr_o  <= |pend_q;
      if (|pend_q) log_entry_o <= door_diag_pkg::EV_TAB[log_idx].ev;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault latch, acknowledge and restart sequence
  assign fb_rise   = control_word_i[door_diag_pkg::CW1_ACK_BIT] && !cw_ack_q;
  assign term_rise = s2_q[7] && !s3_q[7];
  assign ack_take  = (st_q == ST_FAULT)
                  && ((online_i && fb_rise) || term_rise || !online_i);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cw_ack_q <= 1'h0;
      fault_q  <= '0;
    end else if (ce_i) begin
      cw_ack_q <= control_word_i[door_diag_pkg::CW1_ACK_BIT];
      fault_q  <= (fault_q & ~{NEV{ack_take}}) | fault_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q           <= ST_RUN;
      wait_q         <= 16'h0000;
      selftest_req_o <= 1'h0;
    end else if (ce_i) begin
      selftest_req_o <= 1'h0;
      unique case (st_q)
        ST_RUN:   if (|fault_q) st_q <= ST_FAULT;
        ST_FAULT: if (ack_take) begin
          st_q   <= ST_WAIT;
          wait_q <= max_wait;
        end
        ST_WAIT:  if (wait_q == 16'h0000) begin
          st_q           <= ST_TEST;
          selftest_req_o <= 1'h1;
        end else if (sec_tick) begin
          wait_q <= wait_q - 16'h0001;
        end
        ST_TEST:  if (selftest_done_i) st_q <= (|fault_q) ? ST_FAULT : ST_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      motor_en_o    <= 1'h0;
      door_stop_o   <= 1'h0;
      seg_code_o    <= 8'h00;
      event_code_o  <= 8'h00;
      status_word_o <= 16'h0000;
    end else if (ce_i) begin
      motor_en_o    <= (st_q == ST_RUN) && !(|fault_q);
      door_stop_o   <= estop_any;
      seg_code_o    <= top.code;
      event_code_o  <= top.code;
      status_word_o <= 16'h0000;
      status_word_o[door_diag_pkg::SW1_ERR_BIT] <= online_i && |fault_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_err_bit_online: assert property (ce_i |=> status_word_o[3] == $past(online_i && |fault_q))
    else $error("status error bit wrong");
  a_motor_off_recovery: assert property (ce_i && st_q != ST_RUN |=> !motor_en_o)
    else $error("motor driven during recovery");
  a_ack_clears_all: assert property (ce_i && ack_take && fault_set == '0 |=> fault_q == '0)
    else $error("faults left after acknowledge");
  a_ack_edge_only: assert property (ce_i && st_q == ST_FAULT && online_i && cw_ack_q
    && control_word_i[door_diag_pkg::CW1_ACK_BIT] && !term_rise |=> st_q == ST_FAULT)
    else $error("held acknowledge level taken");
  a_offline_auto_ack: assert property (ce_i && st_q == ST_FAULT && !online_i |=> st_q == ST_WAIT)
    else $error("offline fault not acknowledged");
  a_erm_follows_in: assert property (ce_i && s2_q[6] |=> erm_o ##0 erm_cnt_q == $past(erm_dly_q))
    else $error("release not following input");
  a_sf_err_gate: assert property (ce_i |=> sf_err_o == ($past(cfg_q[11:8]) & $past(blk_fault)))
    else $error("safety error gating wrong");
  a_estop_min_wait: assert property (ce_i && ack_take && estop_any |=> wait_q >= 16'h0005)
    else $error("emergency wait below 5 s");
  a_fault_top_rank: assert property (|fault_q |-> top.cls == door_diag_pkg::CLS_FAULT)
    else $error("fault not ranked first");

  c_ack_to_wait: cover property (st_q == ST_FAULT ##1 st_q == ST_WAIT);
  c_restart_run: cover property (st_q == ST_TEST ##1 st_q == ST_RUN);
  c_refault_loop: cover property (st_q == ST_TEST ##1 st_q == ST_FAULT);
  c_log_write: cover property (log_wr_o && log_entry_o.cls == door_diag_pkg::CLS_WARN);

endmodule

// file: fieldbus_ctrl_model.sv
`timescale 1ns/1ps
module fieldbus_ctrl_model (
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        enable_i,
  input  wire logic        hold_i,
  input  wire logic [7:0]  delay_i,
  input  wire logic [15:0] status_word_i,
  output logic      [15:0] control_word_o
);
  logic [7:0] cnt_q;
  logic       ack_q;

  // Retries the acknowledge while the error bit stays set
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 8'h00;
      ack_q <= 1'h0;
    end else if (enable_i && status_word_i[3]) begin
      if (cnt_q == delay_i + 8'h04) begin
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
      ack_q <= (cnt_q >= delay_i);
    end else begin
      cnt_q <= 8'h00;
      ack_q <= 1'h0;
    end
  end

  assign control_word_o = {8'h00, ack_q | hold_i, 7'h00};
endmodule

// file: door_fault_status_and_safety_config_tb.sv
`timescale 1ns/1ps
module door_fault_status_and_safety_config_tb;
  localparam int unsigned SEC = 4000;
  logic               sys_clk_i, nrst_i, wr_i, rd_i, online_i, term_ack_i;
  logic               selftest_done_i, erm_in_i, hold_ack, model_en;
  logic               motor_en_o, door_stop_o, selftest_req_o, log_wr_o, erm_o;
  logic [3:0]         addr_i, subst_show_o, sf_err_o;
  logic [15:0]        wdata_i, rdata_o, control_word_i, status_word_o, d;
  logic [7:0]         ev_active_i, seg_code_o, event_code_o, v, mdelay;
  logic [1:0]         and_a_i, and_b_i, frq_in_i, and_o, frq_det_o;
  door_diag_pkg::ev_t log_entry_o;
  int                 errors, total_checks, n;

  door_diag #(.MS_CYCLES(4)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ev_active_i(ev_active_i), .online_i(online_i), .control_word_i(control_word_i),
    .status_word_o(status_word_o), .term_ack_i(term_ack_i), .seg_code_o(seg_code_o),
    .event_code_o(event_code_o), .motor_en_o(motor_en_o), .door_stop_o(door_stop_o),
    .selftest_req_o(selftest_req_o), .selftest_done_i(selftest_done_i),
    .log_entry_o(log_entry_o), .log_wr_o(log_wr_o), .and_a_i(and_a_i), .and_b_i(and_b_i),
    .frq_in_i(frq_in_i), .erm_in_i(erm_in_i), .and_o(and_o), .frq_det_o(frq_det_o),
    .subst_show_o(subst_show_o), .sf_err_o(sf_err_o), .erm_o(erm_o));

  fieldbus_ctrl_model partner (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .enable_i(model_en),
    .hold_i(hold_ack), .delay_i(mdelay), .status_word_i(status_word_o),
    .control_word_o(control_word_i));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] dat);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= dat;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask

  // Top event: highest class, then lowest priority number, then lowest index
  function automatic logic [7:0] exp_top(input logic [7:0] act);
    logic [7:0] code;
    logic [1:0] bc;
    logic [3:0] bp;
    code = 8'h00;
    bc = 2'h0;
    bp = 4'hF;
    for (int i = 0; i < door_diag_pkg::NEV; i++) begin
      if (act[i] && (door_diag_pkg::EV_TAB[i].ev.cls > bc ||
          (door_diag_pkg::EV_TAB[i].ev.cls == bc && door_diag_pkg::EV_TAB[i].prio < bp))) begin
        bc = door_diag_pkg::EV_TAB[i].ev.cls;
        bp = door_diag_pkg::EV_TAB[i].prio;
        code = door_diag_pkg::EV_TAB[i].ev.code;
      end
    end
    return code;
  endfunction

  // Waits for self-test start, motor must stay off meanwhile
  task automatic recover(input int ws);
    n = 0;
    while (selftest_req_o !== 1'b1 && n < 30000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
      chk({15'h0, motor_en_o}, 16'h0000);
    end
    chk(16'(n >= ws * SEC - 20 && n <= ws * SEC + 200), 16'h0001);
    @(posedge sys_clk_i);
    selftest_done_i <= 1'b1;
    @(posedge sys_clk_i);
    selftest_done_i <= 1'b0;
    cyc(3);
    #1;
    chk({15'h0, motor_en_o}, 16'h0001);
    chk({8'h00, event_code_o}, 16'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #2_300_000;
    errors++;
    test_done();
  end

  initial begin
    {wr_i, rd_i, online_i, term_ack_i, selftest_done_i, erm_in_i, hold_ack, model_en} = 8'h00;
    {addr_i, wdata_i, ev_active_i, and_a_i, and_b_i, frq_in_i} = 34'h0;
    errors = 0;
    total_checks = 0;
    nrst_i = 1'b0;
    void'($urandom(32'h1A73));
    mdelay = 8'($urandom_range(20, 3));
    cyc(4);
    nrst_i <= 1'b1;
    cyc(3);
    rd_chk(door_diag_pkg::R_SUBST, 16'h0302);
    rd_chk(door_diag_pkg::R_FREQ_DETECTOR_0, 16'h0000);
    for (int a = 3; a < 7; a++) rd_chk(4'(a), 16'h00FA);
    rd_chk(door_diag_pkg::R_ERM, 16'h000A);
    rd_chk(4'hC, 16'h0000);
    d = 16'($urandom_range(1000));
    wr_reg(door_diag_pkg::R_AND1_OFF, d);
    rd_chk(door_diag_pkg::R_AND1_OFF, d);
    wr_reg(door_diag_pkg::R_AND1_ON, 16'hFFFF);
    rd_chk(door_diag_pkg::R_AND1_ON, 16'h03E8);
    wr_reg(door_diag_pkg::R_ERM, 16'hFFFF);
    rd_chk(door_diag_pkg::R_ERM, 16'hFFFF);
    // Discrepancy on block 0 with a 2 ms on delay
    wr_reg(door_diag_pkg::R_AND0_ON, 16'h0002);
    and_a_i <= 2'b01;
    cyc(30);
    #1;
    chk({11'h0, and_o[0], subst_show_o[1:0], sf_err_o[1:0]}, 16'h0001);
    wr_reg(door_diag_pkg::R_SUBST, 16'h0001);
    cyc(3);
    #1;
    chk({12'h0, subst_show_o[1:0], sf_err_o[1:0]}, 16'h0004);
    and_a_i <= 2'b00;
    cyc(10);
    and_a_i <= 2'b01;
    and_b_i <= 2'b01;
    cyc(10);
    #1;
    chk({15'h0, and_o[0]}, 16'h0001);
    wr_reg(door_diag_pkg::R_FREQ_DETECTOR_1, 16'h0003);
    rd_chk(door_diag_pkg::R_FREQ_DETECTOR_1, 16'h0001);
    repeat (8) begin
      cyc(SEC / 2);
      frq_in_i <= ~frq_in_i;
    end
    cyc(5);
    #1;
    chk({14'h0, frq_det_o}, 16'h0002);
    wr_reg(door_diag_pkg::R_ERM, 16'h0002);
    erm_in_i <= 1'b1;
    cyc(6);
    #1;
    chk({15'h0, erm_o}, 16'h0001);
    erm_in_i <= 1'b0;
    cyc(SEC - 20);
    #1;
    chk({15'h0, erm_o}, 16'h0001);
    cyc(SEC + 100);
    #1;
    chk({15'h0, erm_o}, 16'h0000);
    ev_active_i <= 8'h10;
    n = 0;
    while (log_wr_o !== 1'b1 && n < 6) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(16'(log_entry_o), 16'h0220);
    repeat (12) begin
      v = 8'($urandom) & 8'hF0;
      ev_active_i <= v;
      cyc(5);
      #1;
      chk({event_code_o, seg_code_o}, {exp_top(v), exp_top(v)});
    end
    // Terminal key acknowledge, online, partner silent
    online_i <= 1'b1;
    ev_active_i <= 8'h01;
    @(posedge sys_clk_i);
    ev_active_i <= 8'h00;
    cyc(20);
    #1;
    chk(status_word_o, 16'h0008);
    term_ack_i <= 1'b1;
    cyc(2);
    term_ack_i <= 1'b0;
    cyc(20);
    #1;
    chk(status_word_o, 16'h0000);
    nrst_i <= 1'b0;
    cyc(4);
    nrst_i <= 1'b1;
    cyc(3);
    // Two faults and a warning, acknowledge bit held high beforehand
    hold_ack <= 1'b1;
    model_en <= 1'b1;
    ev_active_i <= 8'h15;
    @(posedge sys_clk_i);
    ev_active_i <= 8'h10;
    cyc(5);
    #1;
    chk({8'h00, event_code_o}, {8'h00, exp_top(8'h15)});
    chk({14'h0, motor_en_o, door_stop_o}, 16'h0001);
    ev_active_i <= 8'h00;
    cyc(60);
    #1;
    chk(status_word_o, 16'h0008);
    hold_ack <= 1'b0;
    n = 0;
    while (status_word_o[3] !== 1'b0 && n < 100) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(status_word_o, 16'h0000);
    recover(5);
    online_i <= 1'b0;
    ev_active_i <= 8'h04;
    @(posedge sys_clk_i);
    ev_active_i <= 8'h00;
    #1;
    chk(status_word_o, 16'h0000);
    recover(5);
    test_done();
  end
endmodule
